/* rtl/bus_policy_pkg.sv */
// Overview of operation
// - Write-enable picks flash mode; else page-select picks page or ordinary.
// - After reset the mode is ordinary ROM with both select bits clear.
// - Flash writes only run in flash mode; reads run the same in every mode.
// - ROM writes in ordinary ROM mode never assert the shared strobe.
// - 8-bit mode single bytes are read from data bits 7..0; writes drive the byte on both 7..0 and 15..8.
// - 16-bit mode bytes use 7..0 for even, 15..8 for odd.
// - No dynamic sizing; a multi-byte access to an 8-bit device runs as one 16-bit access.
// - 16-bit target in 16-bit mode takes any byte or multi-byte size.
// - Expansion width mode comes from the address alone.
// - Low 2 MiB of 0x17/0x15 run 16-bit, of 0x16/0x14 run 8-bit.
// - Display data is bit-inverted both ways across the pins.
// - No ready across two refresh ticks means deadlock, an illegal access.
// - Accesses to the reserved ranges are illegal.
// - An illegal read answers with a bus error on the command bus.
// - An illegal write raises and holds the level-0 interrupt.
// - Writing one to the clear bit clears the interrupt; zero does nothing.
// - The error flag reads one while the interrupt is pending.
package bus_policy_pkg;
  typedef enum logic [1:0] {
    MODE_ROM   = 2'b00,
    MODE_PAGE  = 2'b01,
    MODE_FLASH = 2'b10
  } rom_mode_e;
  typedef enum logic [3:0] {
    SP_NONE  = 4'b0000,
    SP_ROM   = 4'b0001,
    SP_IO16  = 4'b0010,
    SP_IO8   = 4'b0011,
    SP_MEM16 = 4'b0100,
    SP_MEM8  = 4'b0101,
    SP_REG   = 4'b0110,
    SP_LCD   = 4'b0111,
    SP_DRAM  = 4'b1000,
    SP_RSVD  = 4'b1001
  } space_e;
  // Address bits 28..24 select a 16 MiB region
  localparam logic [4:0] RGN_ROM_A = 5'h1f;
  localparam logic [4:0] RGN_ROM_B = 5'h18;
  localparam logic [4:0] RGN_IO16 = 5'h17;
  localparam logic [4:0] RGN_IO8 = 5'h16;
  localparam logic [4:0] RGN_MEM16 = 5'h15;
  localparam logic [4:0] RGN_MEM8 = 5'h14;
  localparam logic [4:0] RGN_REG = 5'h0b;
  localparam logic [4:0] RGN_LCD = 5'h0a;
  localparam logic [4:0] RGN_DRAM = 5'h00;
  localparam logic [4:0] RSV_A_LO = 5'h19;
  localparam logic [4:0] RSV_A_HI = 5'h1e;
  localparam logic [4:0] RSV_B_LO = 5'h0c;
  localparam logic [4:0] RSV_B_HI = 5'h13;
  localparam logic [4:0] RSV_C_LO = 5'h04;
  localparam logic [4:0] RSV_C_HI = 5'h09;
  // Address bits 23..21 select the 2 MiB window inside a region
  localparam logic [2:0] WIN_LOW = 3'h0;
  localparam logic [4:0] SIZE_BYTE = 5'h01;
  localparam logic [2:0] FIXED_ACCESS_CYCLES = 3'h4;
  localparam logic [11:0] REFRESH_SHORT_CYCLES = 12'h0202;
  localparam logic [11:0] REFRESH_LONG_CYCLES = 12'h080b;
  localparam logic [1:0] DEADLOCK_TICKS = 2'h2;
endpackage

/* rtl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  // New value counts once the second and third stages agree
  always_comb
  begin
    out_d = (s2_q == s3_q) ? s3_q : out_q;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule

/* rtl/refresh_tick.sv */
`timescale 1ns/1ps
module refresh_tick (
  input wire logic clk,
  input wire logic rst,
  input wire logic interval_long,
  output logic tick
);
  import bus_policy_pkg::*;
  logic [11:0] cnt_q, cnt_d, last;
  logic tick_q, tick_d;

  // Free-running refresh opportunity divider
  always_comb
  begin
    last = interval_long ? REFRESH_LONG_CYCLES - 12'h0001
                         : REFRESH_SHORT_CYCLES - 12'h0001;
    tick_d = (cnt_q >= last);
    cnt_d = tick_d ? 12'h0000 : cnt_q + 12'h0001;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_q <= 12'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule

/* rtl/external_bus_access_policy.sv */
`timescale 1ns/1ps
module external_bus_access_policy (
  input wire logic clk,
  input wire logic rst,
  input wire logic flash_write_mode_select,
  input wire logic page_read_mode_select,
  input wire logic refresh_interval_long,
  input wire logic bus_error_clear,
  input wire logic req_valid,
  input wire logic [31:0] req_addr,
  input wire logic req_write,
  input wire logic [4:0] req_size,
  input wire logic [15:0] req_wdata,
  output logic req_ready,
  output logic resp_valid,
  output logic [15:0] resp_rdata,
  output logic core_command_bus_error,
  output logic level0_interrupt,
  output logic bus_error_flag,
  output bus_policy_pkg::rom_mode_e rom_mode,
  input wire logic ext_ready,
  input wire logic [15:0] ext_data_in,
  output logic [15:0] ext_data_out,
  output logic ext_data_oe,
  output logic ext_addr0,
  output logic high_byte_en_n,
  output logic rom_cs_n,
  output logic display_chip_select_n,
  output logic io_cs_n,
  output logic mem_cs_n,
  output logic ram_cs_n,
  output logic rd_n,
  output logic wr_n
);
  import bus_policy_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } state_e;

  logic ready_s, tick;
  logic [15:0] data_s;

  pin_sync #(.W(1)) u_rdy_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(ext_ready),
    .sync_out(ready_s)
  );

  pin_sync #(.W(16)) u_data_sync (
    .clk(clk),
    .rst(rst),
    .pin_in(ext_data_in),
    .sync_out(data_s)
  );

  refresh_tick u_refresh (
    .clk(clk),
    .rst(rst),
    .interval_long(refresh_interval_long),
    .tick(tick)
  );

  // Address decode of the incoming request
  space_e sp;
  logic [4:0] rgn;
  logic low_win, single, accept, rsvd_hit;
  logic [7:0] wbyte;
  always_comb
  begin
    rgn = req_addr[28:24];
    low_win = (req_addr[23:21] == WIN_LOW);
    single = (req_size == SIZE_BYTE);
    wbyte = req_addr[0] ? req_wdata[15:8] : req_wdata[7:0];
    sp = SP_NONE;
    if ((rgn >= RSV_A_LO && rgn <= RSV_A_HI)
        || (rgn >= RSV_B_LO && rgn <= RSV_B_HI)
        || (rgn >= RSV_C_LO && rgn <= RSV_C_HI))
      sp = SP_RSVD;
    else if (rgn == RGN_ROM_A || rgn == RGN_ROM_B)
      sp = SP_ROM;
    else if (rgn == RGN_IO16 && low_win)
      sp = SP_IO16;
    else if (rgn == RGN_IO8 && low_win)
      sp = SP_IO8;
    else if (rgn == RGN_MEM16 && low_win)
      sp = SP_MEM16;
    else if (rgn == RGN_MEM8 && low_win)
      sp = SP_MEM8;
    else if (rgn == RGN_REG)
      sp = SP_REG;
    else if (rgn == RGN_LCD && low_win)
      sp = SP_LCD;
    else if (rgn == RGN_DRAM && !req_addr[23])
      sp = SP_DRAM;
    rsvd_hit = (sp == SP_RSVD);
  end

  state_e state_q, state_d;
  rom_mode_e mode_q, mode_d;
  space_e space_q, space_d;
  logic write_q, write_d, single_q, single_d;
  logic [2:0] cnt_q, cnt_d;
  logic [1:0] ticks_q, ticks_d;
  logic ready_q, ready_d, rvalid_q, rvalid_d;
  logic [15:0] rdata_q, rdata_d, dout_q, dout_d;
  logic cmderr_q, cmderr_d, irq_q, irq_d, set_ev;
  logic oe_q, oe_d, a0_q, a0_d, shb_n_q, shb_n_d;
  logic romcs_n_q, romcs_n_d, disp_n_q, disp_n_d;
  logic iocs_n_q, iocs_n_d, memcs_n_q, memcs_n_d;
  logic ramcs_n_q, ramcs_n_d, rd_n_q, rd_n_d, wr_n_q, wr_n_d;
  logic narrow, ready_sp, finish, dead;

  assign accept = req_valid && ready_q && (state_q == ST_IDLE);

  // Next state of the access sequencer, pins and error flag
  always_comb
  begin
    state_d = state_q;
    space_d = space_q;
    write_d = write_q;
    single_d = single_q;
    cnt_d = cnt_q;
    ticks_d = ticks_q;
    rvalid_d = 1'b0;
    rdata_d = rdata_q;
    cmderr_d = cmderr_q;
    dout_d = dout_q;
    oe_d = oe_q;
    a0_d = a0_q;
    shb_n_d = shb_n_q;
    romcs_n_d = romcs_n_q;
    disp_n_d = disp_n_q;
    iocs_n_d = iocs_n_q;
    memcs_n_d = memcs_n_q;
    ramcs_n_d = ramcs_n_q;
    rd_n_d = rd_n_q;
    wr_n_d = wr_n_q;
    set_ev = 1'b0;
    finish = 1'b0;
    dead = 1'b0;
    if (flash_write_mode_select)
      mode_d = MODE_FLASH;
    else if (page_read_mode_select)
      mode_d = MODE_PAGE;
    else
      mode_d = MODE_ROM;
    narrow = (space_q == SP_IO8) || (space_q == SP_MEM8);
    ready_sp = narrow || (space_q == SP_IO16) || (space_q == SP_MEM16)
               || (space_q == SP_LCD);
    case (state_q)
      ST_IDLE:
      begin
        if (accept)
        begin
          space_d = sp;
          write_d = req_write;
          single_d = single;
          a0_d = req_addr[0];
          cnt_d = FIXED_ACCESS_CYCLES;
          ticks_d = 2'h0;
          cmderr_d = 1'b0;
          if (rsvd_hit)
          begin
            // No pin but ext_addr0 moves; answer at once
            state_d = ST_DONE;
            rvalid_d = 1'b1;
            cmderr_d = !req_write;
            set_ev = req_write;
            rdata_d = 16'h0000;
          end
          else
          begin
            state_d = ST_WAIT;
            rd_n_d = req_write;
            wr_n_d = !req_write;
            oe_d = req_write;
            romcs_n_d = !(sp == SP_ROM);
            iocs_n_d = !(sp == SP_IO16 || sp == SP_IO8);
            memcs_n_d = !(sp == SP_MEM16 || sp == SP_MEM8);
            ramcs_n_d = !(sp == SP_DRAM);
            // Shared pin: display select, or flash write strobe
            disp_n_d = !((sp == SP_LCD) || ((sp == SP_ROM) && req_write
                         && (mode_q == MODE_FLASH)));
            if (sp == SP_LCD)
              dout_d = ~req_wdata;
            else if ((sp == SP_IO8 || sp == SP_MEM8) && single)
              dout_d = {wbyte, wbyte};
            else
              dout_d = req_wdata;
            if (sp == SP_IO8 || sp == SP_MEM8)
              shb_n_d = single;
            else
              shb_n_d = single && !req_addr[0];
          end
        end
      end
      ST_WAIT:
      begin
        if (ready_sp)
        begin
          if (ready_s)
            finish = 1'b1;
          else if (tick && ticks_q == DEADLOCK_TICKS - 2'h1)
            dead = 1'b1;
          else if (tick)
            ticks_d = ticks_q + 2'h1;
        end
        else if (cnt_q == 3'h1)
          finish = 1'b1;
        else
          cnt_d = cnt_q - 3'h1;
        if (finish || dead)
        begin
          state_d = ST_DONE;
          rvalid_d = 1'b1;
          cmderr_d = dead && !write_q;
          set_ev = dead && write_q;
          if (space_q == SP_LCD)
            rdata_d = ~data_s;
          else if (narrow && single_q)
            rdata_d = {data_s[7:0], data_s[7:0]};
          else
            rdata_d = data_s;
          oe_d = 1'b0;
          romcs_n_d = 1'b1;
          disp_n_d = 1'b1;
          iocs_n_d = 1'b1;
          memcs_n_d = 1'b1;
          ramcs_n_d = 1'b1;
          rd_n_d = 1'b1;
          wr_n_d = 1'b1;
          shb_n_d = 1'b1;
        end
      end
      ST_DONE:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
    ready_d = (state_d == ST_IDLE);
    irq_d = set_ev || (irq_q && !bus_error_clear);
  end

  // Register stage; reset gives ordinary ROM mode and idle pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q <= ST_IDLE;
      mode_q <= MODE_ROM;
      space_q <= SP_NONE;
      write_q <= 1'b0;
      single_q <= 1'b0;
      cnt_q <= 3'h0;
      ticks_q <= 2'h0;
      ready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 16'h0000;
      cmderr_q <= 1'b0;
      irq_q <= 1'b0;
      dout_q <= 16'h0000;
      oe_q <= 1'b0;
      a0_q <= 1'b0;
      shb_n_q <= 1'b1;
      romcs_n_q <= 1'b1;
      disp_n_q <= 1'b1;
      iocs_n_q <= 1'b1;
      memcs_n_q <= 1'b1;
      ramcs_n_q <= 1'b1;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
    end
    else
    begin
      state_q <= state_d;
      mode_q <= mode_d;
      space_q <= space_d;
      write_q <= write_d;
      single_q <= single_d;
      cnt_q <= cnt_d;
      ticks_q <= ticks_d;
      ready_q <= ready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      cmderr_q <= cmderr_d;
      irq_q <= irq_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      a0_q <= a0_d;
      shb_n_q <= shb_n_d;
      romcs_n_q <= romcs_n_d;
      disp_n_q <= disp_n_d;
      iocs_n_q <= iocs_n_d;
      memcs_n_q <= memcs_n_d;
      ramcs_n_q <= ramcs_n_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
    end
  end

  // Outputs straight from flops
  assign req_ready = ready_q;
  assign resp_valid = rvalid_q;
  assign resp_rdata = rdata_q;
  assign core_command_bus_error = cmderr_q;
  assign level0_interrupt = irq_q;
  assign bus_error_flag = irq_q;
  assign rom_mode = mode_q;
  assign ext_data_out = dout_q;
  assign ext_data_oe = oe_q;
  assign ext_addr0 = a0_q;
  assign high_byte_en_n = shb_n_q;
  assign rom_cs_n = romcs_n_q;
  assign display_chip_select_n = disp_n_q;
  assign io_cs_n = iocs_n_q;
  assign mem_cs_n = memcs_n_q;
  assign ram_cs_n = ramcs_n_q;
  assign rd_n = rd_n_q;
  assign wr_n = wr_n_q;

  // Checks on the sequencer
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  AST_MODE_SELECT: assert property (
    flash_write_mode_select |=> rom_mode == MODE_FLASH)
    else $error("flash select did not give flash mode");
  AST_RSVD_SILENT: assert property (
    accept && rsvd_hit |=> rom_cs_n && io_cs_n && mem_cs_n && ram_cs_n
      && display_chip_select_n && wr_n && resp_valid)
    else $error("reserved access moved a pin");
  AST_ROM_WR_BLOCK: assert property (
    accept && sp == SP_ROM && req_write && rom_mode == MODE_ROM
      |=> display_chip_select_n [*4])
    else $error("rom write strobe in ordinary rom mode");
  AST_READ_ERR: assert property (
    accept && rsvd_hit && !req_write
      |=> resp_valid && core_command_bus_error && !level0_interrupt
        || resp_valid && core_command_bus_error && $past(level0_interrupt))
    else $error("illegal read gave no bus error");
  AST_WRITE_IRQ: assert property (
    accept && rsvd_hit && req_write
      |=> level0_interrupt && !core_command_bus_error)
    else $error("illegal write gave no interrupt");
  AST_IRQ_CLEAR: assert property (
    level0_interrupt && bus_error_clear && !set_ev |=> !level0_interrupt)
    else $error("clear did not drop interrupt");
  AST_IRQ_HOLD: assert property (
    level0_interrupt && !bus_error_clear |=> level0_interrupt)
    else $error("interrupt dropped without clear");
  AST_LCD_INVERT: assert property (
    accept && sp == SP_LCD && req_write
      |=> ext_data_out == ~$past(req_wdata) && !display_chip_select_n)
    else $error("display write data not inverted");
  AST_LANE8: assert property (
    accept && sp == SP_IO8 && single && req_write
      |=> ext_data_out[7:0] == $past(wbyte) && high_byte_en_n)
    else $error("8-bit byte not on low lane");
  AST_LANE16_ODD: assert property (
    accept && sp == SP_IO16 && single && req_addr[0] && req_write
      |=> ext_data_out[15:8] == $past(req_wdata[15:8]) && !high_byte_en_n)
    else $error("16-bit odd byte not on high lane");
  AST_DEADLOCK: assert property (
    state_q == ST_WAIT && ready_sp && !ready_s && tick
      && ticks_q == 2'h1 |=> resp_valid && (core_command_bus_error
      || level0_interrupt))
    else $error("deadlock not reported");
endmodule

/* verification/ext_target_model.sv */
`timescale 1ns/1ps
module ext_target_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic stall,
  input wire logic [15:0] drive_value,
  output logic ready,
  output logic [15:0] bus_in
);
  logic [2:0] wait_q;
  logic [2:0] wait_d;
  logic [15:0] last_q;
  logic [15:0] last_d;
  // Count strobe cycles of a selected access
  always_comb
  begin
    wait_d = wait_q;
    if (sel_n || (rd_n && wr_n))
      wait_d = 3'h0;
    else if (wait_q != 3'h7)
      wait_d = wait_q + 3'h1;
    last_d = bus_in;
  end
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wait_q <= 3'h0;
      last_q <= 16'h0000;
    end
    else
    begin
      wait_q <= wait_d;
      last_q <= last_d;
    end
  end
  // A stalled target never answers, so the bus can lock up
  assign ready = !stall && (wait_q >= 3'h2);
  // Released data lines flip every cycle so stale data never looks valid
  assign bus_in = rd_n ? ~last_q : drive_value;
endmodule

/* verification/external_bus_access_policy_bench.sv */
`timescale 1ns/1ps
module external_bus_access_policy_bench;
  import bus_policy_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic flash_sel = 1'b0;
  logic page_sel = 1'b0;
  logic rlong = 1'b0;
  logic bus_error_clear = 1'b0;
  logic req_valid = 1'b0;
  logic [31:0] req_addr = 32'h0000_0000;
  logic req_write = 1'b0;
  logic [4:0] req_size = 5'h01;
  logic [15:0] req_wdata = 16'h0000;
  logic stall = 1'b0;
  logic [15:0] dev_data = 16'h3c96;
  logic req_ready, resp_valid, core_command_bus_error;
  logic level0_interrupt, bus_error_flag, ext_ready, ext_data_oe;
  logic ext_addr0, high_byte_en_n, rom_cs_n, display_chip_select_n;
  logic io_cs_n, mem_cs_n, ram_cs_n, rd_n, wr_n;
  logic [15:0] resp_rdata, ext_data_in, ext_data_out;
  rom_mode_e rom_mode;
  int failures = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [5:0] seen_pins = 6'h00;
  logic [15:0] seen_wdata = 16'h0000;
  logic seen_hbe_n = 1'b1;
  logic seen_oe = 1'b0;
  logic seen_a0 = 1'b0;
  logic [15:0] got_data;
  logic got_err;
  logic [31:0] rsv [6] = '{32'h1900_0000, 32'h1eff_fffe, 32'h0c00_0000,
    32'h13ff_fffe, 32'h0400_0000, 32'h09ff_fffe};
  logic [31:0] legal [4] = '{32'h18ff_fffe, 32'h0bff_fffe, 32'h0a1f_fffe,
    32'h1420_0000};

  external_bus_access_policy uut (
    .clk, .rst, .flash_write_mode_select(flash_sel),
    .page_read_mode_select(page_sel), .refresh_interval_long(rlong),
    .bus_error_clear, .req_valid, .req_addr, .req_write, .req_size,
    .req_wdata, .req_ready, .resp_valid, .resp_rdata,
    .core_command_bus_error, .level0_interrupt, .bus_error_flag,
    .rom_mode, .ext_ready, .ext_data_in, .ext_data_out, .ext_data_oe,
    .ext_addr0, .high_byte_en_n, .rom_cs_n, .display_chip_select_n,
    .io_cs_n, .mem_cs_n, .ram_cs_n, .rd_n, .wr_n
  );
  ext_target_model model (
    .clk, .rst, .sel_n(io_cs_n & mem_cs_n & display_chip_select_n),
    .rd_n, .wr_n, .stall, .drive_value(dev_data), .ready(ext_ready),
    .bus_in(ext_data_in)
  );

  // Clock and hang guard
  always #2 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 15000)
    begin
      failures++;
      $display("mismatch at %0t: run timed out", $time);
      complete_run();
    end
  end

  // Pin monitor: strobes seen and data on the pins during an access
  always @(negedge clk)
  begin
    seen_pins |= ~{rom_cs_n, display_chip_select_n, io_cs_n, mem_cs_n,
      ram_cs_n, wr_n};
    if (wr_n === 1'b0 || rd_n === 1'b0)
    begin
      seen_hbe_n = high_byte_en_n;
      seen_oe = ext_data_oe;
      seen_a0 = ext_addr0;
    end
    if (wr_n === 1'b0)
      seen_wdata = ext_data_out;
  end

  task automatic complete_run();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One core request, held until taken, then wait for its answer
  // The core issues one beat per request
  task automatic access(input logic [31:0] a, input logic w,
    input logic [4:0] sz, input logic [15:0] wd);
    int n;
    @(posedge clk);
    seen_pins = 6'h00;
    req_addr <= a;
    req_write <= w;
    req_size <= sz;
    req_wdata <= wd;
    req_valid <= 1'b1;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    req_valid <= 1'b0;
    n = 0;
    @(negedge clk);
    while (resp_valid !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    chk({15'h0000, resp_valid}, 16'h0001, "answer");
    got_data = resp_rdata;
    got_err = core_command_bus_error;
  endtask

  // Access with checks of selects, data lanes and byte enable
  task automatic xfer(input logic [31:0] a, input logic w,
    input logic [4:0] sz, input logic [15:0] wd, input logic [4:0] cs,
    input logic [15:0] dat, input logic hbe_n);
    access(a, w, sz, wd);
    chk({10'h000, seen_pins}, {10'h000, cs, w}, "selects");
    chk(w ? seen_wdata : got_data, dat, "data");
    chk({15'h0000, seen_hbe_n}, {15'h0000, hbe_n}, "byte enable");
    chk({14'h0000, seen_oe, seen_a0}, {14'h0000, w, a[0]}, "oe and a0");
    chk({15'h0000, got_err}, 16'h0000, "error");
  endtask

  task automatic set_mode(input logic f, input logic p);
    @(posedge clk);
    flash_sel <= f;
    page_sel <= p;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic irq_is(input logic v);
    @(negedge clk);
    chk({15'h0000, level0_interrupt}, {15'h0000, v}, "interrupt");
    chk({15'h0000, bus_error_flag}, {15'h0000, v}, "error flag");
  endtask

  task automatic clear_irq();
    @(posedge clk);
    bus_error_clear <= 1'b1;
    @(posedge clk);
    bus_error_clear <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    repeat (19) @(posedge clk);
    @(negedge clk);
    chk({14'h0000, rom_mode}, {14'h0000, MODE_ROM}, "reset mode");
    irq_is(1'b0);
    @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      set_mode(i[1], i[0]);
      chk({14'h0000, rom_mode}, {14'h0000, i[1] ? MODE_FLASH : i[0] ?
        MODE_PAGE : MODE_ROM}, "mode");
    end
    set_mode(1'b0, 1'b0);
    access(32'h1f00_0000, 1'b1, 5'h02, 16'h1234);
    chk({15'h0000, seen_pins[4]}, 16'h0000, "rom strobe");
    access(32'h1f00_0000, 1'b0, 5'h10, 16'h0000);
    chk({15'h0000, seen_pins[5]}, 16'h0001, "rom read");
    access(32'h0000_0000, 1'b0, 5'h10, 16'h0000);
    chk({15'h0000, seen_pins[1]}, 16'h0001, "dram select");
    chk({15'h0000, got_err}, 16'h0000, "dram error");
    set_mode(1'b0, 1'b1);
    access(32'h1800_0000, 1'b0, 5'h04, 16'h0000);
    chk({15'h0000, seen_pins[5]}, 16'h0001, "page read");
    set_mode(1'b1, 1'b1);
    access(32'h1f00_0000, 1'b1, 5'h02, 16'h1234);
    chk({15'h0000, seen_pins[4]}, 16'h0001, "flash strobe");
    set_mode(1'b0, 1'b0);
    xfer(32'h1600_0001, 1, 5'h01, 16'ha55a, 5'h04, 16'ha5a5, 1);
    xfer(32'h1600_0000, 1, 5'h01, 16'ha55a, 5'h04, 16'h5a5a, 1);
    xfer(32'h1600_0001, 0, 5'h01, 16'h0000, 5'h04, 16'h9696, 1);
    xfer(32'h1400_0000, 0, 5'h01, 16'h0000, 5'h02, 16'h9696, 1);
    xfer(32'h1700_0001, 1, 5'h01, 16'ha55a, 5'h04, 16'ha55a, 0);
    xfer(32'h1700_0000, 1, 5'h01, 16'ha55a, 5'h04, 16'ha55a, 1);
    xfer(32'h1500_0001, 0, 5'h01, 16'h0000, 5'h02, 16'h3c96, 0);
    xfer(32'h1500_0000, 0, 5'h10, 16'h0000, 5'h02, 16'h3c96, 0);
    xfer(32'h0a00_0000, 1, 5'h02, 16'h1234, 5'h08, 16'hedcb, 0);
    xfer(32'h0a00_0000, 0, 5'h08, 16'h0000, 5'h08, 16'hc369, 0);
    for (int i = 0; i < 4; i++)
    begin
      access(legal[i], 1'b0, 5'h02, 16'h0000);
      chk({15'h0000, got_err}, 16'h0000, "no error");
    end
    for (int i = 0; i < 6; i++)
    begin
      access(rsv[i], 1'b0, 5'h02, 16'h0000);
      chk({15'h0000, got_err}, 16'h0001, "read error");
      irq_is(1'b0);
      access(rsv[i], 1'b1, 5'h02, 16'h00ff);
      chk({10'h000, seen_pins}, 16'h0000, "no strobes");
      repeat (6) @(posedge clk);
      irq_is(1'b1);
      clear_irq();
      irq_is(1'b0);
    end
    @(posedge clk);
    stall <= 1'b1;
    access(32'h1700_0000, 1'b0, 5'h02, 16'h0000);
    chk({15'h0000, got_err}, 16'h0001, "deadlock read");
    access(32'h0a00_0000, 1'b1, 5'h02, 16'h0000);
    irq_is(1'b1);
    clear_irq();
    irq_is(1'b0);
    stall <= 1'b0;
    xfer(32'h1700_0000, 0, 5'h02, 16'h0000, 5'h04, 16'h3c96, 0);
    complete_run();
  end
endmodule
